// ### rtl/conversion_control_status_ctrl.sv
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "conversion_control_status_defines.svh"
module conversion_control_status_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // activation sources
  input wire logic ext_trigger,
  input wire logic timer_underflow,
  // conversion core
  input wire logic core_done,
  input wire logic core_scan_end,
  input wire logic [9:0] core_data,
  output logic core_start,
  output logic core_abort,
  // dma controller
  input wire logic dma_clear,
  input wire logic dma_active,
  // interrupt request
  output logic eoc_irq
);

  conversion_control_status_pkg::conversion_control_status_state_all_t r;
  conversion_control_status_pkg::conversion_control_status_state_all_t next_r;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a[11:2] == off[11:2]);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = is_addr(a, `CONVERSION_CONTROL_STATUS_OFF_CTRL) || is_addr(a, `CONVERSION_CONTROL_STATUS_OFF_MODE) ||
             is_addr(a, `CONVERSION_CONTROL_STATUS_OFF_RESULT) || is_addr(a, `CONVERSION_CONTROL_STATUS_OFF_CORE);
  endfunction

  logic wr_fire;
  logic wr_ctrl;
  logic wr_mode;
  logic sw_stop;
  logic sw_start;
  logic sw_eoc_clr;
  logic ext_act;
  logic tmr_act;
  logic any_act;
  logic single;
  logic protect;
  logic store;

  always_comb begin
    wr_fire = r.wr.aw_got && r.wr.w_got && !r.wr.bvalid;
    wr_ctrl = wr_fire && is_addr(r.wr.awaddr, `CONVERSION_CONTROL_STATUS_OFF_CTRL) && r.wr.wstrb[1];
    wr_mode = wr_fire && is_addr(r.wr.awaddr, `CONVERSION_CONTROL_STATUS_OFF_MODE) && r.wr.wstrb[0];
    sw_stop = wr_ctrl && !r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_BUSY];
    sw_start = wr_ctrl && r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_SOFTWARE_ACTIVATION_BIT];
    sw_eoc_clr = (wr_ctrl && !r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_INT]) || dma_clear;
    ext_act = r.sts[0] && r.trig_prev && !ext_trigger;
    tmr_act = r.sts[1] && timer_underflow;
    // simultaneous sources merge into one start in this cycle
    any_act = sw_start || ext_act || tmr_act;
    single = (r.mode == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_MD_SINGLE1) || (r.mode == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_MD_SINGLE2);
    protect = r.end_of_conversion_irq_enable && r.eoc;
    store = core_done && (r.state == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_CONV) && !protect;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.core.start = 1'b0;
    next_r.core.abort = 1'b0;
    next_r.trig_prev = ext_trigger;
    next_r.dma_busy_q = dma_active;

    // write channel
    if (s_axi_awvalid && r.wr.awready) begin
      next_r.wr.aw_got = 1'b1;
      next_r.wr.awaddr = s_axi_awaddr;
      next_r.wr.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wr.wready) begin
      next_r.wr.w_got = 1'b1;
      next_r.wr.wdata = s_axi_wdata;
      next_r.wr.wstrb = s_axi_wstrb;
      next_r.wr.wready = 1'b0;
    end
    if (wr_fire) begin
      next_r.wr.bvalid = 1'b1;
      next_r.wr.bresp = mapped(r.wr.awaddr) ? `CONVERSION_CONTROL_STATUS_RESP_OKAY : `CONVERSION_CONTROL_STATUS_RESP_SLVERR;
    end
    if (r.wr.bvalid && s_axi_bready) begin
      next_r.wr.bvalid = 1'b0;
      next_r.wr.aw_got = 1'b0;
      next_r.wr.w_got = 1'b0;
      next_r.wr.awready = 1'b1;
      next_r.wr.wready = 1'b1;
    end

    // register writes
    if (wr_ctrl) begin
      next_r.end_of_conversion_irq_enable = r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_END_OF_CONVERSION_IRQ_ENABLE];
      next_r.sts = r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_STS_HI:`CONVERSION_CONTROL_STATUS_BIT_STS_LO];
      // pause flag write has no effect on conversion
      if (r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_PAUSE_FLAG] || !dma_active) begin
        next_r.pause = r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_PAUSE_FLAG];
      end
    end
    if (wr_mode) begin
      next_r.mode = conversion_control_status_pkg::conversion_control_status_mode_t'(
        r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_MD_HI:`CONVERSION_CONTROL_STATUS_BIT_MD_LO]);
      next_r.buf_en = r.wr.wdata[`CONVERSION_CONTROL_STATUS_BIT_BUFEN];
    end

    // end of conversion flag: clear has priority
    if (store) begin
      next_r.eoc = 1'b1;
      next_r.result = core_data;
    end
    if (sw_eoc_clr) begin
      next_r.eoc = 1'b0;
    end

    // sequencer
    case (r.state)
      conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_IDLE: begin
        if (any_act && !sw_stop) begin
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_CONV;
          next_r.busy = 1'b1;
          next_r.core.start = 1'b1;
        end
      end
      conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_CONV: begin
        if (core_done && protect) begin
          // unread result: hold off the store instead of losing it
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_HOLD;
          next_r.pause = 1'b1;
        end else if (store && r.buf_en && r.end_of_conversion_irq_enable) begin
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_HOLD;
          next_r.pause = 1'b1;
        end else if (store && r.mode == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_MD_PAUSE) begin
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_HOLD;
          next_r.pause = 1'b1;
        end else if (store && core_scan_end && single) begin
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_IDLE;
          next_r.busy = 1'b0;
        end else if (store && core_scan_end) begin
          // continuous: the core runs one scan per start, so rearm it
          next_r.core.start = 1'b1;
        end else if (any_act && r.mode == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_MD_SINGLE1) begin
          next_r.core.start = 1'b1;
        end
      end
      conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_HOLD: begin
        if (r.mode == conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_MD_PAUSE && !protect && !(r.buf_en && r.end_of_conversion_irq_enable && r.eoc)) begin
          if (any_act) begin
            next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_CONV;
            next_r.core.start = 1'b1;
          end
        end else if (!r.eoc) begin
          next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_CONV;
          next_r.core.start = 1'b1;
        end
      end
      default: begin
        next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_IDLE;
      end
    endcase

    // stop wins over any activation
    if (sw_stop) begin
      next_r.state = conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_IDLE;
      next_r.busy = 1'b0;
      next_r.core.start = 1'b0;
      next_r.core.abort = (r.state != conversion_control_status_pkg::CONVERSION_CONTROL_STATUS_ST_IDLE);
    end

    next_r.core.irq = next_r.eoc && next_r.end_of_conversion_irq_enable;

    // read channel
    if (s_axi_arvalid && r.rd.arready) begin
      next_r.rd.arready = 1'b0;
      next_r.rd.rvalid = 1'b1;
      next_r.rd.rresp = mapped(s_axi_araddr) ? `CONVERSION_CONTROL_STATUS_RESP_OKAY : `CONVERSION_CONTROL_STATUS_RESP_SLVERR;
      next_r.rd.rdata = 32'h0000_0000;
      if (is_addr(s_axi_araddr, `CONVERSION_CONTROL_STATUS_OFF_CTRL)) begin
        // software_activation_bit reads zero, reserved bits zero
        next_r.rd.rdata[15:8] = {r.busy, r.eoc, r.end_of_conversion_irq_enable, r.pause, r.sts, 2'b00};
      end else if (is_addr(s_axi_araddr, `CONVERSION_CONTROL_STATUS_OFF_MODE)) begin
        next_r.rd.rdata[7:0] = {r.mode, 5'h00, r.buf_en};
      end else if (is_addr(s_axi_araddr, `CONVERSION_CONTROL_STATUS_OFF_RESULT)) begin
        next_r.rd.rdata[9:0] = r.result;
      end else if (is_addr(s_axi_araddr, `CONVERSION_CONTROL_STATUS_OFF_CORE)) begin
        next_r.rd.rdata[2:0] = {r.dma_busy_q, r.state};
      end
    end
    if (r.rd.rvalid && s_axi_rready) begin
      next_r.rd.rvalid = 1'b0;
      next_r.rd.arready = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.wr.awready <= 1'b1;
      r.wr.wready <= 1'b1;
      r.rd.arready <= 1'b1;
      r.trig_prev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // rmw sees busy and eoc as one: software must write 1 to keep them
  // this is a bus convention, the bus cannot tell rmw from a plain write
  assign s_axi_awready = r.wr.awready;
  assign s_axi_wready = r.wr.wready;
  assign s_axi_bvalid = r.wr.bvalid;
  assign s_axi_bresp = r.wr.bresp;
  assign s_axi_arready = r.rd.arready;
  assign s_axi_rvalid = r.rd.rvalid;
  assign s_axi_rdata = r.rd.rdata;
  assign s_axi_rresp = r.rd.rresp;
  assign core_start = r.core.start;
  assign core_abort = r.core.abort;
  assign eoc_irq = r.core.irq;

endmodule

// ### rtl/conversion_control_status_defines.svh
`ifndef CONVERSION_CONTROL_STATUS_DEFINES_SVH
`define CONVERSION_CONTROL_STATUS_DEFINES_SVH

// register byte addresses
`define CONVERSION_CONTROL_STATUS_OFF_CTRL 12'h000
`define CONVERSION_CONTROL_STATUS_OFF_MODE 12'h004
`define CONVERSION_CONTROL_STATUS_OFF_RESULT 12'h008
`define CONVERSION_CONTROL_STATUS_OFF_CORE 12'h00c

// control status high byte field positions
`define CONVERSION_CONTROL_STATUS_BIT_BUSY 15
`define CONVERSION_CONTROL_STATUS_BIT_INT 14
`define CONVERSION_CONTROL_STATUS_BIT_END_OF_CONVERSION_IRQ_ENABLE 13
`define CONVERSION_CONTROL_STATUS_BIT_PAUSE_FLAG 12
`define CONVERSION_CONTROL_STATUS_BIT_STS_HI 11
`define CONVERSION_CONTROL_STATUS_BIT_STS_LO 10
`define CONVERSION_CONTROL_STATUS_BIT_SOFTWARE_ACTIVATION_BIT 9

// mode register field positions
`define CONVERSION_CONTROL_STATUS_BIT_MD_HI 7
`define CONVERSION_CONTROL_STATUS_BIT_MD_LO 6
`define CONVERSION_CONTROL_STATUS_BIT_BUFEN 0

// reset values
`define CONVERSION_CONTROL_STATUS_CTRL_RST 8'h00
`define CONVERSION_CONTROL_STATUS_MODE_RST 2'h0

// axi responses
`define CONVERSION_CONTROL_STATUS_RESP_OKAY 2'h0
`define CONVERSION_CONTROL_STATUS_RESP_SLVERR 2'h2

`endif

// ### rtl/conversion_control_status_pkg.sv
package conversion_control_status_pkg;

  typedef enum logic [1:0] {
    CONVERSION_CONTROL_STATUS_MD_SINGLE1 = 2'b00,
    CONVERSION_CONTROL_STATUS_MD_SINGLE2 = 2'b01,
    CONVERSION_CONTROL_STATUS_MD_CONT = 2'b10,
    CONVERSION_CONTROL_STATUS_MD_PAUSE = 2'b11
  } conversion_control_status_mode_t;

  typedef enum logic [1:0] {
    CONVERSION_CONTROL_STATUS_ST_IDLE = 2'b00,
    CONVERSION_CONTROL_STATUS_ST_CONV = 2'b01,
    CONVERSION_CONTROL_STATUS_ST_HOLD = 2'b10
  } conversion_control_status_state_t;

  // axi write side
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
  } conversion_control_status_wr_t;

  // axi read side
  typedef struct packed {
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } conversion_control_status_rd_t;

  // converter side outputs: core start and abort, plus the interrupt request
  typedef struct packed {
    logic start;
    logic abort;
    logic irq;
  } conversion_control_status_core_t;

  typedef struct packed {
    conversion_control_status_wr_t wr;
    conversion_control_status_rd_t rd;
    conversion_control_status_core_t core;
    conversion_control_status_state_t state;
    logic busy;
    logic eoc;
    logic end_of_conversion_irq_enable;
    logic pause;
    logic [1:0] sts;
    conversion_control_status_mode_t mode;
    logic buf_en;
    logic [9:0] result;
    logic trig_prev;
    logic dma_busy_q;
  } conversion_control_status_state_all_t;

endpackage

// ### dv/conversion_control_status_core_model.sv
`timescale 1ns/1ps
module conversion_control_status_core_model #(
  parameter int DLY = 12
) (
  // block side
  input wire logic aclk,
  input wire logic core_start,
  input wire logic core_abort,
  // results
  output logic core_done,
  output logic core_scan_end,
  output logic [9:0] core_data
);
  int cnt = 0;
  logic [9:0] d = 10'h000;
  // one-channel scans, so every result ends the scan
  assign core_scan_end = core_done;
  // released lines show the inverse so a stale value never matches
  assign core_data = core_done ? d : ~d;
  always @(posedge aclk) begin
    core_done <= cnt == 1;
    if (cnt == 1) d <= d + 10'h0a5;
    if (core_abort) cnt <= 0;
    else if (core_start) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

// ### dv/conversion_control_status_ctrl_checker.sv
`timescale 1ns/1ps
module conversion_control_status_ctrl_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // converter side
  input wire logic ext_trigger,
  input wire logic timer_underflow,
  input wire logic core_start,
  input wire logic core_abort,
  input wire logic dma_clear,
  input wire logic eoc_irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // shadows follow only writes whose address and data land together
  logic [1:0] sts_sh, md_sh;
  logic rd_ctrl, wr_go, ctl_go, s1q;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign ctl_go = wr_go && s_axi_awaddr == 12'h000 && s_axi_wstrb[1];
  assign s1q = s_axi_awready && !s_axi_awvalid && !s_axi_bvalid && md_sh == 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_sh <= 2'h0;
      md_sh <= 2'h0;
      rd_ctrl <= 1'b0;
    end else begin
      if (ctl_go) sts_sh <= s_axi_wdata[11:10];
      if (wr_go && s_axi_awaddr == 12'h004 && s_axi_wstrb[0]) md_sh <= s_axi_wdata[7:6];
      if (s_axi_arvalid && s_axi_arready) rd_ctrl <= s_axi_araddr == 12'h000;
    end
  end
  a_start_abort_excl: assert property (!(core_start && core_abort))
    else $error("start and abort together");
  a_software_activation_bit_reads_zero: assert property (s_axi_rvalid && rd_ctrl |-> !s_axi_rdata[9])
    else $error("activation bit read as one");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_clear_drops_irq: assert property (dma_clear |-> ##[1:2] !eoc_irq)
    else $error("irq kept after dma clear");
  a_trig_starts: assert property ($fell(ext_trigger) && sts_sh[0] && s1q |=> core_start)
    else $error("trigger edge did not start");
  a_timer_starts: assert property (timer_underflow && sts_sh[1] && s1q |=> core_start)
    else $error("timer did not start");
  a_off_no_start: assert property ($fell(ext_trigger) && !sts_sh[0] && !timer_underflow && s1q
    |=> !core_start)
    else $error("disabled trigger started");
  a_keep_no_abort: assert property (ctl_go && s_axi_wdata[15] |=> !core_abort [*3])
    else $error("busy one write aborted");
  a_no_restart: assert property (core_start && md_sh != 2'b00 |=> !core_start [*8])
    else $error("restart while converting");
endmodule

// ### dv/test_adc_control_status_sequencer.sv
`timescale 1ns/1ps
module test_adc_control_status_sequencer;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dma_clear = 1'b0, dma_active = 1'b0;
  logic ext_trigger = 1'b1, timer_underflow = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic core_done, core_scan_end, core_start, core_abort, eoc_irq;
  logic [9:0] core_data;
  int err_total = 0, checks_done = 0;
  always #4 aclk = ~aclk;
  conversion_control_status_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger, .timer_underflow,
    .core_done, .core_scan_end, .core_data, .core_start, .core_abort, .dma_clear,
    .dma_active, .eoc_irq);
  conversion_control_status_core_model m (.aclk, .core_start, .core_abort, .core_done, .core_scan_end,
    .core_data);
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] k, input logic [31:0] e);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & k, e);
    @(posedge aclk);
  endtask
  // polls busy; a hung conversion ends the run here
  task automatic idle();
    int n = 0;
    do begin
      rc(12'h000, 32'h0200, 32'h0);
      if (++n > 40) hang();
    end while (s_axi_rdata[15]);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h000, 32'hfe00, 32'h0);
    rc(12'h004, 32'hc1, 32'h0);
    wr(12'h000, 32'h0200);
    rc(12'h000, 32'h8000, 32'h0);
    wr(12'h000, 32'h8200);
    rc(12'h000, 32'hc200, 32'h8000);
    idle();
    rc(12'h000, 32'h4000, 32'h4000);
    chk({31'h0, eoc_irq}, 32'h0);
    rc(12'h008, 32'h3ff, {22'h0, m.d});
    wr(12'h000, 32'hc000);
    rc(12'h000, 32'h4000, 32'h4000);
    wr(12'h000, 32'h8000);
    rc(12'h000, 32'h4000, 32'h0);
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h8200);
    repeat (40) @(posedge aclk);
    rc(12'h000, 32'h8000, 32'h8000);
    wr(12'h000, 32'h0);
    rc(12'h000, 32'hc000, 32'h0);
    wr(12'h004, 32'h40);
    wr(12'h000, 32'h8200);
    wr(12'h000, 32'h8200);
    idle();
    wr(12'h004, 32'hc0);
    wr(12'h000, 32'h8200);
    repeat (30) @(posedge aclk);
    rc(12'h000, 32'h9000, 32'h9000);
    rc(12'h008, 32'h3ff, {22'h0, m.d});
    wr(12'h000, 32'h8200);
    repeat (30) @(posedge aclk);
    rc(12'h000, 32'h9000, 32'h9000);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h000, 32'ha200);
    repeat (30) @(posedge aclk);
    rc(12'h000, 32'h9000, 32'h9000);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    // sources changed only while idle, since a change acts at once
    for (int s = 0; s < 4; s++) begin
      wr(12'h000, {16'h0, 1'b1, 3'h0, s[1:0], 10'h0});
      ext_trigger <= 1'b0;
      @(posedge aclk);
      ext_trigger <= 1'b1;
      repeat (3) @(posedge aclk);
      idle();
      rc(12'h000, 32'h4000, {17'h0, s[0], 14'h0});
      wr(12'h000, {16'h0, 1'b1, 3'h0, s[1:0], 10'h0});
      timer_underflow <= 1'b1;
      @(posedge aclk);
      timer_underflow <= 1'b0;
      repeat (3) @(posedge aclk);
      idle();
      rc(12'h000, 32'h4000, {17'h0, s[1], 14'h0});
    end
    wr(12'h000, 32'ha200);
    idle();
    chk({31'h0, eoc_irq}, 32'h1);
    r1 = {22'h0, m.d};
    wr(12'h000, 32'he200);
    repeat (30) @(posedge aclk);
    rc(12'h000, 32'h1000, 32'h1000);
    rc(12'h008, 32'h3ff, r1);
    dma_active <= 1'b1;
    wr(12'h000, 32'hb000);
    wr(12'h000, 32'he000);
    rc(12'h000, 32'h1000, 32'h1000);
    dma_active <= 1'b0;
    wr(12'h000, 32'he000);
    rc(12'h000, 32'h1000, 32'h0);
    idle();
    wr(12'h000, 32'ha200);
    idle();
    dma_clear <= 1'b1;
    @(posedge aclk);
    dma_clear <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, eoc_irq}, 32'h0);
    final_report();
  end
endmodule
bind conversion_control_status_ctrl conversion_control_status_ctrl_checker chk_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .ext_trigger, .timer_underflow, .core_start, .core_abort, .dma_clear,
  .eoc_irq);
